// ### src/lens_diag.sv
`timescale 1ns/10ps
`include "lens_diag_params.svh"
module lens_diag
  import lens_diag_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  input  wire logic        addr_override_in,
  input  wire logic [6:0]  addr_in,
  input  wire logic [7:0]  power_control_in,
  input  wire logic        mode_start_in,
  input  wire logic        mode_fault_in,
  input  wire logic [1:0]  region_en_in,
  input  wire logic        abort_in,
  input  wire logic        reinit_in,
  input  wire logic        clear_faults_in,
  input  wire cfg_t        cfg_in,
  input  wire logic        cal_store_in,
  input  wire logic        cal_region_in,
  input  wire logic [31:0] cal_power_in,
  input  wire logic        burst_done_in,
  input  wire meas_t       meas_in,
  output logic             shutdown_out,
  output logic             busy_out,
  output logic [4:0]       burst_out,
  output logic             burst_start_out,
  output logic             sense_en_out,
  output logic [15:0]      amp_first_out,
  output logic [15:0]      amp_second_out,
  output logic             amp_update_out,
  output logic [31:0]      baseline_first_out,
  output logic [31:0]      baseline_second_out,
  output logic [31:0]      measured_peak_power_first_out,
  output logic [31:0]      measured_peak_power_second_out,
  output logic             open_load_out,
  output logic             damaged_out,
  output logic             addressed_out
);

  //////////////////////////////////////////////////////////////////////////
  // functions

  // sense path only on active bursts; the idle burst keeps it off
  function automatic logic is_active(input logic [4:0] b);
    is_active = (b < `BURST_PASSIVE_LO)
                || (b > `BURST_IDLE && b <= `BURST_ACTIVE_HI);
  endfunction : is_active

  // one step toward the window, saturating at both ends
  function automatic logic [15:0] rescale(input logic [15:0] amp,
                                          input logic [15:0] step,
                                          input logic [31:0] peak,
                                          input logic [31:0] upper,
                                          input logic [31:0] lower);
    rescale = amp;
    if (peak > upper) begin
      rescale = (amp > step) ? amp - step : `AMP_RESET;
    end else if (peak < lower) begin
      rescale = (`AMP_MAX - amp > step) ? amp + step : `AMP_MAX;
    end
  endfunction : rescale

  //////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_q;
  logic rst_n;

  // async assert, two-flop release so all logic leaves reset together
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // working settings and shutdown

  cfg_t work_q;

  // reload from host buffer; a mode start also initialises
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      work_q <= '0;
    end else if (reinit_in || (mode_start_in && !busy_out)) begin
      work_q <= cfg_in;
    end
  end

  // held in shutdown by the host until a mode runs
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_out <= 1'b0;
    end else begin
      shutdown_out <= (power_control_in == `SHUTDOWN_CODE) && !busy_out;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mode sequencer

  seq_state_t state_q;

  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q         <= ST_IDLE;
      burst_out       <= `BURST_IDLE;
      burst_start_out <= 1'b0;
      sense_en_out    <= 1'b0;
      busy_out        <= 1'b0;
    end else begin
      burst_start_out <= 1'b0;
      if (abort_in && busy_out) begin
        state_q   <= ST_IDLE;
        burst_out <= `BURST_IDLE;
        busy_out  <= 1'b0;
        sense_en_out <= is_active(`BURST_IDLE);
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            if (mode_start_in && mode_fault_in) begin
              state_q         <= ST_FAULT;
              burst_out       <= `BURST_FAULT;
              burst_start_out <= 1'b1;
              busy_out        <= 1'b1;
              sense_en_out    <= is_active(`BURST_FAULT);
            end else if (mode_start_in && region_en_in[0]) begin
              state_q         <= ST_PWR_FIRST;
              burst_out       <= `BURST_PWR_FIRST;
              burst_start_out <= 1'b1;
              busy_out        <= 1'b1;
              sense_en_out    <= is_active(`BURST_PWR_FIRST);
            end else if (mode_start_in && region_en_in[1]) begin
              state_q         <= ST_PWR_SECOND;
              burst_out       <= `BURST_PWR_SECOND;
              burst_start_out <= 1'b1;
              busy_out        <= 1'b1;
              sense_en_out    <= is_active(`BURST_PWR_SECOND);
            end
          end
          ST_PWR_FIRST: begin
            if (burst_done_in && region_en_in[1]) begin
              state_q         <= ST_PWR_SECOND;
              burst_out       <= `BURST_PWR_SECOND;
              burst_start_out <= 1'b1;
            end else if (burst_done_in) begin
              state_q <= ST_FINISH;
            end
          end
          ST_PWR_SECOND, ST_FAULT: begin
            if (burst_done_in) begin
              state_q <= ST_FINISH;
            end
          end
          ST_FINISH: begin
            state_q      <= ST_IDLE;
            burst_out    <= `BURST_IDLE;
            busy_out     <= 1'b0;
            sense_en_out <= is_active(`BURST_IDLE);
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // peak tracking over the running burst

  logic [31:0] pk_power_q;
  logic [31:0] pk_cur_q;
  logic [31:0] min_z_q;

  // cleared at each burst start so each region is judged on its own sweep
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pk_power_q <= '0;
      pk_cur_q   <= '0;
      min_z_q    <= '1;
    end else if (burst_start_out) begin
      pk_power_q <= '0;
      pk_cur_q   <= '0;
      min_z_q    <= '1;
    end else if (meas_in.valid && busy_out) begin
      if (meas_in.power > pk_power_q) pk_power_q <= meas_in.power;
      if (meas_in.current > pk_cur_q) pk_cur_q <= meas_in.current;
      if (meas_in.impedance < min_z_q) min_z_q <= meas_in.impedance;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // power results and amplitude update

  logic pwr_done_first;
  logic pwr_done_second;
  logic pwr_finish;
  logic [1:0] ran_q;

  assign pwr_done_first  = (state_q == ST_PWR_FIRST) && burst_done_in;
  assign pwr_done_second = (state_q == ST_PWR_SECOND) && burst_done_in;
  assign pwr_finish      = (state_q == ST_FINISH) && (ran_q != 2'b00);

  // readable peak per region after each power burst
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      measured_peak_power_first_out  <= '0;
      measured_peak_power_second_out <= '0;
      ran_q                          <= 2'b00;
    end else begin
      // kept across both bursts of one run, dropped once back in idle
      if (state_q == ST_IDLE) ran_q <= 2'b00;
      if (pwr_done_first) begin
        measured_peak_power_first_out <= pk_power_q;
        ran_q[0] <= 1'b1;
      end
      if (pwr_done_second) begin
        measured_peak_power_second_out <= pk_power_q;
        ran_q[1] <= 1'b1;
      end
    end
  end

  // one amplitude per region drives its clean, heat and power bursts
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      amp_first_out  <= `AMP_RESET;
      amp_second_out <= `AMP_RESET;
      amp_update_out <= 1'b0;
    end else begin
      amp_update_out <= pwr_finish;
      if (reinit_in && !busy_out) begin
        amp_first_out  <= cfg_in.amp_first;
        amp_second_out <= cfg_in.amp_second;
      end else if (pwr_finish) begin
        if (ran_q[0]) begin
          amp_first_out <= rescale(amp_first_out, work_q.amp_step,
                                   measured_peak_power_first_out,
                                   work_q.upper_first,
                                   work_q.lower_first);
        end
        if (ran_q[1]) begin
          amp_second_out <= rescale(amp_second_out, work_q.amp_step,
                                    measured_peak_power_second_out,
                                    work_q.upper_second,
                                    work_q.lower_second);
        end
      end
    end
  end

  // calibration baselines, one per region
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      baseline_first_out  <= '0;
      baseline_second_out <= '0;
    end else if (cal_store_in) begin
      if (cal_region_in) baseline_second_out <= cal_power_in;
      else baseline_first_out <= cal_power_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // fault decision

  logic        fault_eval;
  logic [31:0] z_dev;

  assign fault_eval = (state_q == ST_FAULT) && burst_done_in;
  assign z_dev = (min_z_q > work_q.z_ref) ? min_z_q - work_q.z_ref
                                          : work_q.z_ref - min_z_q;

  // sticky; a new fault in the clearing cycle still lands
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      open_load_out <= 1'b0;
      damaged_out   <= 1'b0;
    end else begin
      if (fault_eval && (pk_cur_q < work_q.cur_thresh)) begin
        open_load_out <= 1'b1;
      end else if (clear_faults_in) begin
        open_load_out <= 1'b0;
      end
      if (fault_eval && (z_dev > work_q.z_thresh)) begin
        damaged_out <= 1'b1;
      end else if (clear_faults_in) begin
        damaged_out <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial target address phase

  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic       scl_q;
  logic       sda_q;
  logic       scl_old_q;
  logic       sda_old_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  tgt_state_t tgt_q;
  logic [6:0] own_addr;

  assign own_addr = addr_override_in ? addr_in : `TGT_ADDR_DEFAULT;

  // three-flop sync; a level counts once the last two stages agree
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      scl_old_q  <= 1'b1;
      sda_old_q  <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      if (scl_sync_q[1] == scl_sync_q[2]) scl_q <= scl_sync_q[2];
      if (sda_sync_q[1] == sda_sync_q[2]) sda_q <= sda_sync_q[2];
      scl_old_q <= scl_q;
      sda_old_q <= sda_q;
    end
  end

  // acks only its own address; data bytes are left to the buffer logic
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tgt_q         <= I_IDLE;
      bit_cnt_q     <= 4'h0;
      shift_q       <= 8'h00;
      sda_out       <= 1'b1;
      sda_oe_out    <= 1'b0;
      addressed_out <= 1'b0;
    end else if (scl_q && sda_old_q && !sda_q) begin
      tgt_q      <= I_ADDR;
      bit_cnt_q  <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (scl_q && !sda_old_q && sda_q) begin
      tgt_q         <= I_IDLE;
      sda_oe_out    <= 1'b0;
      addressed_out <= 1'b0;
    end else begin
      unique case (tgt_q)
        I_IDLE, I_HOLD: begin
        end
        I_ADDR: begin
          if (!scl_old_q && scl_q) begin
            shift_q   <= {shift_q[6:0], sda_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_old_q && !scl_q && bit_cnt_q == 4'h8) begin
            if (shift_q[7:1] == own_addr) begin
              tgt_q         <= I_ACK;
              sda_out       <= 1'b0;
              sda_oe_out    <= 1'b1;
              addressed_out <= 1'b1;
            end else begin
              tgt_q <= I_HOLD;
            end
          end
        end
        I_ACK: begin
          if (scl_old_q && !scl_q) begin
            tgt_q      <= I_HOLD;
            sda_oe_out <= 1'b0;
            sda_out    <= 1'b1;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_pwr_launch;
    state_q == ST_IDLE && mode_start_in && !mode_fault_in && !abort_in
      && region_en_in[0];
  endsequence
  sequence s_first_running;
    burst_out == `BURST_PWR_FIRST && burst_start_out && sense_en_out;
  endsequence

  property p_pwr_launch;
    @(posedge ref_clk_in) disable iff (!rst_n)
      s_pwr_launch |=> s_first_running;
  endproperty
  a_pwr_launch: assert property (p_pwr_launch)
    else $error("power mode did not start on first region burst");

  property p_sense;
    @(posedge ref_clk_in) disable iff (!rst_n)
      sense_en_out == is_active(burst_out);
  endproperty
  a_sense: assert property (p_sense)
    else $error("sense path enable disagrees with burst number");

  property p_abort;
    @(posedge ref_clk_in) disable iff (!rst_n)
      abort_in && busy_out |=> burst_out == `BURST_IDLE && !busy_out;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not return to idle burst");

  property p_idle_end;
    @(posedge ref_clk_in) disable iff (!rst_n)
      $fell(busy_out) |-> burst_out == `BURST_IDLE;
  endproperty
  a_idle_end: assert property (p_idle_end)
    else $error("mode ended away from idle burst");

  property p_sticky;
    @(posedge ref_clk_in) disable iff (!rst_n)
      open_load_out && !clear_faults_in |=> open_load_out;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("open load flag dropped without clear");

  property p_open_load;
    @(posedge ref_clk_in) disable iff (!rst_n)
      fault_eval && pk_cur_q < work_q.cur_thresh |=> open_load_out;
  endproperty
  a_open_load: assert property (p_open_load)
    else $error("low current did not raise open load");

  property p_hold_amp;
    @(posedge ref_clk_in) disable iff (!rst_n)
      pwr_finish && ran_q[0] && !reinit_in
        && measured_peak_power_first_out <= work_q.upper_first
        && measured_peak_power_first_out >= work_q.lower_first
        |=> $stable(amp_first_out) && amp_update_out;
  endproperty
  a_hold_amp: assert property (p_hold_amp)
    else $error("in-window power changed amplitude");

  property p_shutdown;
    @(posedge ref_clk_in) disable iff (!rst_n)
      power_control_in == `SHUTDOWN_CODE && !busy_out |=> shutdown_out;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown code not reflected");

  property p_reinit;
    @(posedge ref_clk_in) disable iff (!rst_n)
      reinit_in && !busy_out |=> amp_second_out == $past(cfg_in.amp_second);
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("reinitialise did not reload amplitude");

endmodule : lens_diag

// ### src/lens_diag_params.svh
// Operation
// - each power burst finds peak real power in its own region.
// - measured peak versus thresholds steers that region's cleaning amplitude.
// - fault burst finds max current and min impedance, judges the load.
// - power mode runs at most two power bursts, one per region.
// - each region keeps and is regulated against its own limit pair.
// - after power mode new amplitude goes to bursts 8-17, 20 and 21.
// - calibration peak power kept in two baseline registers, one per region.
// - power mode peak power kept in two readable flag registers.
// - device answers as serial target at 7-bit address, default 0x48.
// - power control code 0x10 means software shutdown until a mode starts.
// - abort stops whichever mode is running.
// - reinitialise reloads working settings from the host buffer.
// - fault and flag bits stay set until clear-faults.
// - bursts 0-5 and 19-23 enable sense path, 6-17 do not.
// - every mode ends back on idle burst 18.
`ifndef LENS_DIAG_PARAMS_SVH
`define LENS_DIAG_PARAMS_SVH
`define TGT_ADDR_DEFAULT  7'h48
`define SHUTDOWN_CODE     8'h10
`define BURST_IDLE        5'h12
`define BURST_PWR_FIRST   5'h14
`define BURST_PWR_SECOND  5'h15
`define BURST_FAULT       5'h16
`define BURST_PASSIVE_LO  5'h06
`define BURST_PASSIVE_HI  5'h11
`define BURST_ACTIVE_HI   5'h17
`define AMP_RESET         16'h0000
`define AMP_MAX           16'hffff
`endif

// ### src/lens_diag_pkg.sv
package lens_diag_pkg;
  // buffered host settings, copied to the working set on reinitialise
  typedef struct packed {
    logic [15:0] amp_first;
    logic [15:0] amp_second;
    logic [15:0] amp_step;
    logic [31:0] upper_first;
    logic [31:0] lower_first;
    logic [31:0] upper_second;
    logic [31:0] lower_second;
    logic [31:0] cur_thresh;
    logic [31:0] z_thresh;
    logic [31:0] z_ref;
  } cfg_t;
  // one sample from the current and voltage sense path
  typedef struct packed {
    logic        valid;
    logic [31:0] power;
    logic [31:0] current;
    logic [31:0] impedance;
  } meas_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_PWR_FIRST, ST_PWR_SECOND, ST_FAULT, ST_FINISH
  } seq_state_t;
  typedef enum logic [1:0] {I_IDLE, I_ADDR, I_ACK, I_HOLD} tgt_state_t;
endpackage : lens_diag_pkg

// ### dv/lens_host_model.sv
`timescale 1ns/10ps
module lens_host_model (
  input  wire logic ref_clk_in,
  input  wire logic sda_dev_in,
  input  wire logic sda_oe_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic host_rel;
  // open-drain line with pull-up: high unless somebody pulls it down
  assign sda_out = host_rel & ~(sda_oe_in & ~sda_dev_in);
  initial begin
    scl_out  = 1'b1;
    host_rel = 1'b1;
  end
  // phases kept well above the device's input sync delay
  task automatic wait_ph;
    repeat (8) @(posedge ref_clk_in);
  endtask : wait_ph
  // start condition, address with write bit, then ack slot
  task automatic send_addr(input logic [6:0] addr, output logic ack);
    logic [7:0] b;
    b = {addr, 1'b0};
    @(posedge ref_clk_in);
    host_rel <= 1'b0;
    wait_ph();
    for (int i = 7; i >= 0; i--) begin
      scl_out  <= 1'b0;
      host_rel <= b[i];
      wait_ph();
      scl_out <= 1'b1;
      wait_ph();
    end
    scl_out  <= 1'b0;
    host_rel <= 1'b1;
    wait_ph();
    scl_out <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    #1;
    ack = ~sda_out;  // sampled mid-phase, away from any edge
    wait_ph();
  endtask : send_addr
  // stop condition: sda rises while scl is high
  task automatic stop;
    wait_ph();
    scl_out <= 1'b0;
    wait_ph();
    host_rel <= 1'b0;
    wait_ph();
    scl_out <= 1'b1;
    wait_ph();
    host_rel <= 1'b1;
    wait_ph();
  endtask : stop
endmodule : lens_host_model

// ### dv/lens_power_fault_diagnostics_bench.sv
`timescale 1ns/10ps
`include "lens_diag_params.svh"
module lens_power_fault_diagnostics_bench
  import lens_diag_pkg::*;
;
  logic        clk, nrst, scl, sda, sda_d, sda_oe, ovr, start, fmode;
  logic        abort, reinit, clr, cal_st, cal_rg, done;
  logic        shut, busy, bstart, sense, upd, opn, dmg, adr;
  logic [6:0]  addr;
  logic [7:0]  pctl;
  logic [1:0]  ren;
  logic [4:0]  burst;
  logic [15:0] amp1, amp2, ea1, ea2;
  logic [31:0] cal_pw, base1, base2, pk1, pk2;
  cfg_t        cfg;
  meas_t       meas;
  int          n_mismatch, check_count, cycles;

  lens_diag dut (
    .ref_clk_in(clk), .nrst_in(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_d), .sda_oe_out(sda_oe), .addr_override_in(ovr),
    .addr_in(addr), .power_control_in(pctl), .mode_start_in(start),
    .mode_fault_in(fmode), .region_en_in(ren), .abort_in(abort),
    .reinit_in(reinit), .clear_faults_in(clr), .cfg_in(cfg),
    .cal_store_in(cal_st), .cal_region_in(cal_rg), .cal_power_in(cal_pw),
    .burst_done_in(done), .meas_in(meas), .shutdown_out(shut),
    .busy_out(busy), .burst_out(burst), .burst_start_out(bstart),
    .sense_en_out(sense), .amp_first_out(amp1), .amp_second_out(amp2),
    .amp_update_out(upd), .baseline_first_out(base1),
    .baseline_second_out(base2), .measured_peak_power_first_out(pk1),
    .measured_peak_power_second_out(pk2), .open_load_out(opn),
    .damaged_out(dmg), .addressed_out(adr)
  );
  lens_host_model host (
    .ref_clk_in(clk), .sda_dev_in(sda_d), .sda_oe_in(sda_oe),
    .scl_out(scl), .sda_out(sda)
  );
  // free-running 200 MHz clock
  always #2.5 clk = ~clk;
  // hang guard, far above the roughly 900 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic summarize;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  // one valid sense sample
  task automatic sample(input logic [31:0] p, c, z);
    @(posedge clk) meas <= '{1'b1, p, c, z};
    @(posedge clk) meas.valid <= 1'b0;
  endtask : sample
  // burst finished; taken at the second edge
  task automatic fin;
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
  endtask : fin
  // expected amplitude after a power run
  function automatic logic [15:0] resc(logic [15:0] a, logic [31:0] p, u, l);
    if (p > u)
      return (a > cfg.amp_step) ? a - cfg.amp_step : 16'h0000;
    if (p < l)
      return (a > 16'hffff - cfg.amp_step) ? 16'hffff : a + cfg.amp_step;
    return a;
  endfunction : resc
  ////////////////////////////////////////////////////////////////////////
  task automatic t_shutdown;
    @(posedge clk) pctl <= `SHUTDOWN_CODE;
    repeat (3) @(posedge clk);
    #1 chk("shutdown", 1, shut);
    @(posedge clk) pctl <= 8'h00;
    repeat (3) @(posedge clk);
    #1 chk("shutdown off", 0, shut);
  endtask : t_shutdown
  task automatic t_reinit;
    @(posedge clk) reinit <= 1'b1;
    @(posedge clk) reinit <= 1'b0;
    ea1 = cfg.amp_first;
    ea2 = cfg.amp_second;
    @(posedge clk) #1 chk("reinit amp1", ea1, amp1);
    chk("reinit amp2", ea2, amp2);
  endtask : t_reinit
  // back-to-back baseline stores
  task automatic t_baseline;
    @(posedge clk) {cal_st, cal_rg, cal_pw} <= {2'b10, 32'h0012_3456};
    @(posedge clk) {cal_rg, cal_pw} <= {1'b1, 32'h0abc_def0};
    @(posedge clk) cal_st <= 1'b0;
    @(posedge clk) #1 chk("baseline1", 32'h0012_3456, base1);
    chk("baseline2", 32'h0abc_def0, base2);
  endtask : t_baseline
  task automatic run_power(input logic [1:0] en, input logic [31:0] p1, p2);
    logic [31:0] pv;
    if (en[0]) ea1 = resc(ea1, p1, cfg.upper_first, cfg.lower_first);
    if (en[1]) ea2 = resc(ea2, p2, cfg.upper_second, cfg.lower_second);
    @(posedge clk) {ren, fmode, start} <= {en, 2'b01};
    @(posedge clk) start <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      if (en[r]) begin
        pv = r ? p2 : p1;
        #1;
        chk("power burst", r ? `BURST_PWR_SECOND : `BURST_PWR_FIRST, burst);
        chk("burst start", 1, bstart);
        chk("power sense", 1, sense);
        sample(pv / 4, 0, 0);
        sample(pv, 0, 0);
        sample(pv / 2, 0, 0);
        fin();
      end
    end
    @(posedge clk);
    #1 chk("power end", `BURST_IDLE, burst);
    chk("idle sense", 0, sense);
    chk("power busy", 0, busy);
    chk("amp update", 1, upd);
    chk("amp first", ea1, amp1);
    chk("amp second", ea2, amp2);
    if (en[0]) chk("peak first", p1, pk1);
    if (en[1]) chk("peak second", p2, pk2);
  endtask : run_power
  task automatic t_abort;
    @(posedge clk) {ren, fmode, start} <= 4'b1101;
    @(posedge clk) start <= 1'b0;
    @(posedge clk) abort <= 1'b1;
    #1 chk("busy", 1, busy);
    @(posedge clk) abort <= 1'b0;
    @(posedge clk) #1 chk("abort burst", `BURST_IDLE, burst);
    chk("abort busy", 0, busy);
    chk("abort amp", ea1, amp1);
  endtask : t_abort
  task automatic run_fault(input logic [31:0] c, z, input logic eo, ed);
    @(posedge clk) {fmode, start} <= 2'b11;
    @(posedge clk) start <= 1'b0;
    @(posedge clk) #1 chk("fault burst", `BURST_FAULT, burst);
    chk("fault sense", 1, sense);
    sample(0, c / 2, z + 40);
    sample(0, c, z);
    sample(0, c / 4, z + 80);
    fin();
    @(posedge clk) #1 chk("open load", eo, opn);
    chk("damaged", ed, dmg);
    @(posedge clk) #1 chk("fault end", `BURST_IDLE, burst);
  endtask : run_fault
  task automatic t_clear;
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    @(posedge clk) #1 chk("cleared open", 0, opn);
    chk("cleared damaged", 0, dmg);
  endtask : t_clear
  // address match, release at stop, override and mismatch
  task automatic probe(input logic [6:0] a, input logic exp);
    logic ack;
    host.send_addr(a, ack);
    chk("target ack", exp, ack);
    chk("addressed", exp, adr);
    host.stop();
    #1 chk("released", 0, adr);
  endtask : probe
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, nrst, ovr, start, fmode, abort, reinit, clr, cal_st, done} = '0;
    {cal_rg, addr, pctl, ren, cal_pw, meas} = '0;
    {ea1, ea2, n_mismatch, check_count, cycles} = '0;
    // first-run amplitudes and thresholds set by host
    cfg = '{16'h0100, 16'h0200, 16'h0010, 32'd1000, 32'd500,
            32'd1000, 32'd500, 32'd100, 32'd50, 32'd1000};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("idle burst", `BURST_IDLE, burst);
    chk("reset sda oe", 0, sda_oe);
    t_shutdown();
    t_reinit();
    t_baseline();
    run_power(2'b11, 32'd1200, 32'd800);
    run_power(2'b10, 32'd0, 32'd100);
    run_power(2'b01, 32'd1000, 32'd0);
    t_abort();
    run_fault(32'd80, 32'd1010, 1'b1, 1'b0);
    run_fault(32'd150, 32'd900, 1'b1, 1'b1);
    t_clear();
    probe(7'h48, 1'b1);
    probe(7'h2a, 1'b0);
    @(posedge clk) {ovr, addr} <= {1'b1, 7'h2a};
    probe(7'h2a, 1'b1);
    probe(7'h48, 1'b0);
    summarize();
  end
endmodule : lens_power_fault_diagnostics_bench
